// ==== verilog/plwm_window_map.sv ====
`timescale 1ns/1ns
module plwm_window_map
  import plwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic soft_rst_i,
  input wire logic setup_complete_flag_i,
  input wire logic host_mode_i,
  input wire logic pp_wr_i,
  input wire logic [1:0] pp_sel_i,
  input wire logic [31:0] pp_wdata_i,
  output logic [31:0] pp_rdata_o,
  input wire logic pci_wr_i,
  input wire logic [1:0] pci_sel_i,
  output logic [31:0] pci_rdata_o,
  input wire logic tgt_req_i,
  input wire logic tgt_space_i,
  input wire logic [31:0] tgt_offset_i,
  output logic tgt_accept_o,
  output logic tgt_retry_o,
  output logic [31:0] tgt_local_addr_o
);

  typedef struct packed {
    logic [1:0][PLWM_FIELD_W-1:0] size;
    logic [1:0][PLWM_FIELD_W-1:0] base;
    logic [31:0] pp_rdata;
    logic [31:0] pci_rdata;
    logic accept;
    logic retry;
    logic [31:0] laddr;
  } plwm_state_t;

  plwm_state_t st_r;
  plwm_state_t st_nxt;

  function automatic logic [31:0] plwm_read(input plwm_state_t s, input logic [1:0] sel);
    logic [PLWM_FIELD_W-1:0] f;
    f = '0;
    case (sel)
      PLWM_SEL_SIZE0: f = s.size[0];
      PLWM_SEL_SIZE1: f = s.size[1];
      PLWM_SEL_BASE0: f = s.base[0];
      PLWM_SEL_BASE1: f = s.base[1];
      default: f = '0;
    endcase
    plwm_read = {3'h0, f, 20'h00000};
  endfunction

  logic [31:0] win_mask;
  logic [31:0] base_word;
  logic [PLWM_FIELD_W-1:0] cur_size;
  logic [PLWM_FIELD_W-1:0] cur_base;

  always_comb begin
    st_nxt = st_r;
    win_mask = {3'h0, st_r.size[tgt_space_i], 20'hfffff};
    base_word = {3'h0, st_r.base[tgt_space_i], 20'h00000};
    cur_size = st_r.size[tgt_space_i];
    cur_base = st_r.base[tgt_space_i];
    if (pp_wr_i) begin
      case (pp_sel_i)
        PLWM_SEL_SIZE0: st_nxt.size[0] = pp_wdata_i[PLWM_FIELD_MSB:PLWM_FIELD_LSB];
        PLWM_SEL_SIZE1: st_nxt.size[1] = pp_wdata_i[PLWM_FIELD_MSB:PLWM_FIELD_LSB];
        PLWM_SEL_BASE0: st_nxt.base[0] = pp_wdata_i[PLWM_FIELD_MSB:PLWM_FIELD_LSB];
        PLWM_SEL_BASE1: st_nxt.base[1] = pp_wdata_i[PLWM_FIELD_MSB:PLWM_FIELD_LSB];
        default: st_nxt.size = st_r.size;
      endcase
    end
    st_nxt.pp_rdata = plwm_read(st_r, pp_sel_i);
    st_nxt.pci_rdata = plwm_read(st_r, pci_sel_i);
    st_nxt.accept = 1'b0;
    st_nxt.retry = 1'b0;
    st_nxt.laddr = st_r.laddr;
    if (tgt_req_i) begin
      if (!setup_complete_flag_i && !host_mode_i) begin
        st_nxt.retry = 1'b1;
      end else begin
        st_nxt.accept = 1'b1;
        st_nxt.laddr = (base_word & ~win_mask) | (tgt_offset_i & win_mask);
      end
    end
    if (soft_rst_i) begin
      st_nxt.size = '0;
      st_nxt.base = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_r <= '{size: '0, base: '0, pp_rdata: PLWM_REG_RESET, pci_rdata: PLWM_REG_RESET,
                accept: 1'b0, retry: 1'b0, laddr: PLWM_REG_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pp_rdata_o = st_r.pp_rdata;
  assign pci_rdata_o = st_r.pci_rdata;
  assign tgt_accept_o = st_r.accept;
  assign tgt_retry_o = st_r.retry;
  assign tgt_local_addr_o = st_r.laddr;

  sequence s_pp_write_size0;
    pp_wr_i && pp_sel_i == PLWM_SEL_SIZE0 && !soft_rst_i;
  endsequence

  chk_pp_write_lands: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_pp_write_size0 ##1 (pci_sel_i == PLWM_SEL_SIZE0) |=> pci_rdata_o == ($past(pp_wdata_i, 2) & PLWM_FIELD_MASK))
    else $error("size write not visible from pci side");
  chk_pci_write_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    (pci_wr_i && !pp_wr_i && !soft_rst_i) |=> st_r.size == $past(st_r.size) && st_r.base == $past(st_r.base))
    else $error("pci write changed a register");
  chk_reserved_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    ((pp_rdata_o & ~PLWM_FIELD_MASK) == 32'h0) && ((pci_rdata_o & ~PLWM_FIELD_MASK) == 32'h0))
    else $error("reserved bits read nonzero");
  chk_soft_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_i |=> st_r.size == '0 && st_r.base == '0)
    else $error("soft reset did not clear");
  chk_retry_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && !setup_complete_flag_i && !host_mode_i) |=> tgt_retry_o && !tgt_accept_o)
    else $error("access not retried during setup");
  chk_accept_ready: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && (setup_complete_flag_i || host_mode_i)) |=> tgt_accept_o && !tgt_retry_o)
    else $error("access not accepted after setup");
  chk_min_window: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && setup_complete_flag_i && st_r.size[tgt_space_i] == '0)
      |=> tgt_local_addr_o[19:0] == $past(tgt_offset_i[19:0]) && tgt_local_addr_o[28:20] == $past(base_word[28:20]))
    else $error("1MB window address wrong");
  chk_addr_compose: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && setup_complete_flag_i)
      |=> tgt_local_addr_o[31:29] == 3'h0 && (tgt_local_addr_o & PLWM_LOW_MASK) == ($past(tgt_offset_i) & PLWM_LOW_MASK))
    else $error("local address composition wrong");
  chk_max_window: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && setup_complete_flag_i && &st_r.size[tgt_space_i])
      |=> tgt_local_addr_o == ($past(tgt_offset_i) & 32'h1fff_ffff))
    else $error("512MB window address wrong");

  sequence s_pp_write(logic [1:0] sel);
    pp_wr_i && pp_sel_i == sel && !soft_rst_i;
  endsequence

  sequence s_tgt_open;
    tgt_req_i && (setup_complete_flag_i || host_mode_i);
  endsequence

  sequence s_tgt_closed;
    tgt_req_i && !setup_complete_flag_i && !host_mode_i;
  endsequence

  // Write then read back, one copy per register
  for (genvar g = 0; g < 4; g++) begin : g_readback
    chk_pp_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_pp_write(2'(g)) ##1 (pp_sel_i == 2'(g)) |=> pp_rdata_o == ($past(pp_wdata_i, 2) & PLWM_FIELD_MASK))
      else $error("register write not read back on peripheral side");
    chk_pci_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_pp_write(2'(g)) ##1 (pci_sel_i == 2'(g)) |=> pci_rdata_o == ($past(pp_wdata_i, 2) & PLWM_FIELD_MASK))
      else $error("register write not read back on pci side");
  end

  chk_reset_clear: assert property (@(posedge mclk_i)
    rst_i |=> st_r.size == '0 && st_r.base == '0 && pp_rdata_o == PLWM_REG_RESET && pci_rdata_o == PLWM_REG_RESET)
    else $error("power-on reset did not clear registers");
  chk_reset_quiet: assert property (@(posedge mclk_i)
    rst_i |=> !tgt_accept_o && !tgt_retry_o && tgt_local_addr_o == PLWM_REG_RESET)
    else $error("target outputs not idle after reset");
  chk_soft_readback: assert property (@(posedge mclk_i) disable iff (rst_i)
    soft_rst_i |-> ##2 (pp_rdata_o == PLWM_REG_RESET && pci_rdata_o == PLWM_REG_RESET))
    else $error("registers read nonzero after soft reset");

  chk_size0_local: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_pp_write(PLWM_SEL_SIZE0) |=> st_r.size[1] == $past(st_r.size[1]) && st_r.base == $past(st_r.base))
    else $error("size 0 write disturbed another register");
  chk_size1_local: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_pp_write(PLWM_SEL_SIZE1) |=> st_r.size[0] == $past(st_r.size[0]) && st_r.base == $past(st_r.base))
    else $error("size 1 write disturbed another register");
  chk_base0_local: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_pp_write(PLWM_SEL_BASE0) |=> st_r.base[1] == $past(st_r.base[1]) && st_r.size == $past(st_r.size))
    else $error("base 0 write disturbed another register");
  chk_base1_local: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_pp_write(PLWM_SEL_BASE1) |=> st_r.base[0] == $past(st_r.base[0]) && st_r.size == $past(st_r.size))
    else $error("base 1 write disturbed another register");

  chk_answer_onehot: assert property (@(posedge mclk_i) disable iff (rst_i)
    !(tgt_accept_o && tgt_retry_o))
    else $error("accept and retry shown together");
  chk_idle_silent: assert property (@(posedge mclk_i) disable iff (rst_i)
    !tgt_req_i |=> !tgt_accept_o && !tgt_retry_o)
    else $error("answer shown without request");
  chk_answer_origin: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_accept_o || tgt_retry_o) |-> $past(tgt_req_i))
    else $error("answer not preceded by request");
  chk_host_no_retry: assert property (@(posedge mclk_i) disable iff (rst_i)
    (tgt_req_i && host_mode_i) |=> !tgt_retry_o)
    else $error("host bridge retried an access");
  chk_retry_keeps_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tgt_closed |=> $stable(tgt_local_addr_o))
    else $error("retried access moved the local address");
  chk_addr_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !tgt_req_i |=> $stable(tgt_local_addr_o))
    else $error("local address changed without access");

  chk_base_upper: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tgt_open |=> (tgt_local_addr_o[PLWM_FIELD_MSB:PLWM_FIELD_LSB] & ~$past(cur_size))
      == ($past(cur_base) & ~$past(cur_size)))
    else $error("base bits above capacity not used");
  chk_offset_lower: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tgt_open |=> (tgt_local_addr_o[PLWM_FIELD_MSB:PLWM_FIELD_LSB] & $past(cur_size))
      == ($past(tgt_offset_i[PLWM_FIELD_MSB:PLWM_FIELD_LSB]) & $past(cur_size)))
    else $error("offset bits inside capacity not used");
  chk_area_select: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tgt_open ##0 (!tgt_space_i && st_r.size[0][8:6] == 3'h0)
      |=> tgt_local_addr_o[28:26] == $past(st_r.base[0][8:6]))
    else $error("area bits of base 0 not used");
  chk_area_offset: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_tgt_open ##0 (!tgt_space_i && st_r.size[0] == '0)
      |=> tgt_local_addr_o[25:20] == $past(st_r.base[0][5:0]))
    else $error("position bits of base 0 not used");

endmodule // plwm_window_map

// ==== verilog/plwm_pkg.sv ====
// Operation
// - Size field bits 28..20 hold window capacity minus one in 1MB steps
// - All-zero size field gives the smallest 1MB window
// - All-ones size field gives the largest 512MB window
// - Size and base registers clear on power-on and software reset
// - Peripheral bus reads and writes; PCI side reads only, writes ignored
// - Bits 31..29 and 19..0 read zero; software writes zero there
// - Two independent windows, each with own size and base register
// - Base field bits 28..20 give start address bits 28..20
// - Only base bits above window capacity form the local address
// - Base 0 bits 28..26 pick area, bits 25..20 position within it
// - Until setup complete, non-host target accesses are retried
package plwm_pkg;
  localparam int PLWM_FIELD_LSB = 20;
  localparam int PLWM_FIELD_MSB = 28;
  localparam int PLWM_FIELD_W = PLWM_FIELD_MSB - PLWM_FIELD_LSB + 1;
  localparam logic [31:0] PLWM_REG_RESET = 32'h0000_0000;
  localparam logic [31:0] PLWM_FIELD_MASK = 32'h1ff0_0000;
  localparam logic [31:0] PLWM_LOW_MASK = 32'h000f_ffff;
  localparam int PLWM_AREA_LSB = 26;
  localparam logic [1:0] PLWM_SEL_SIZE0 = 2'h0;
  localparam logic [1:0] PLWM_SEL_SIZE1 = 2'h1;
  localparam logic [1:0] PLWM_SEL_BASE0 = 2'h2;
  localparam logic [1:0] PLWM_SEL_BASE1 = 2'h3;
endpackage

// ==== bench/plwm_pci_master.sv ====
`timescale 1ns/1ns
module plwm_pci_master (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic space_i,
  input wire logic [31:0] offset_i,
  output logic req_o,
  output logic space_o,
  output logic [31:0] offset_o
);
  // One-cycle request, lines scrambled when idle
  always @(posedge mclk_i) begin
    if (rst_i) begin
      req_o <= 1'b0;
      space_o <= 1'b0;
      offset_o <= 32'h0;
    end else begin
      req_o <= go_i;
      space_o <= go_i ? space_i : ~space_o;
      offset_o <= go_i ? offset_i : ~offset_o;
    end
  end
endmodule // plwm_pci_master

// ==== bench/tb.sv ====
`timescale 1ns/1ns
module tb;
  import plwm_pkg::*;
  logic clk = 0, rst = 1, srst = 0, setup = 0, host = 0, ppw = 0, pciw = 0, go = 0, gsp = 0, acc, ret, req, sp;
  logic [1:0] psel = 0, csel = 0;
  logic [31:0] wd = 0, goff = 0, lst = 0, rnd = 32'h31, ppr, pcr, la, off;
  logic [31:0] m [4] = '{default: 32'h0};
  logic [33:0] q [$];
  logic [63:0] rq [$];
  logic rv = 0, rv_d = 0;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  plwm_window_map dut (.mclk_i(clk), .rst_i(rst), .soft_rst_i(srst), .setup_complete_flag_i(setup),
    .host_mode_i(host), .pp_wr_i(ppw), .pp_sel_i(psel), .pp_wdata_i(wd), .pp_rdata_o(ppr), .pci_wr_i(pciw),
    .pci_sel_i(csel), .pci_rdata_o(pcr), .tgt_req_i(req), .tgt_space_i(sp), .tgt_offset_i(off),
    .tgt_accept_o(acc), .tgt_retry_o(ret), .tgt_local_addr_o(la));
  plwm_pci_master pm (.mclk_i(clk), .rst_i(rst), .go_i(go), .space_i(gsp), .offset_i(goff), .req_o(req),
    .space_o(sp), .offset_o(off));
  initial forever #10 clk = ~clk;
  function logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task results;
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR %s exp=%h got=%h", nm, e, s);
    end
  endtask
  task wr(input logic [1:0] s, input logic [31:0] d);
    @(posedge clk) begin ppw <= 1; psel <= s; csel <= s; wd <= d & PLWM_FIELD_MASK; end
    @(posedge clk) ppw <= 0;
    m[s] = d & PLWM_FIELD_MASK;
  endtask
  task rall;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) begin psel <= 2'(i); csel <= 2'(i); pciw <= 1; wd <= 32'hffffffff; rv <= 1; end
      rq.push_back({m[i], m[i]});
      @(posedge clk) begin pciw <= 0; rv <= 0; end
    end
  endtask
  task tg(input logic s, input logic [31:0] o);
    logic [31:0] mk;
    @(posedge clk) begin go <= 1; gsp <= s; goff <= o; end
    mk = m[s] | PLWM_LOW_MASK;
    if (setup | host) lst = (m[2 + s] & ~mk) | (o & mk);
    q.push_back({setup | host, !(setup | host), lst});
    @(posedge clk) go <= 0;
  endtask
  always @(negedge clk) if (acc === 1'b1 || ret === 1'b1) begin
    if (q.size() == 0) chk("tgt_extra", 34'h0, 34'h1);
    else chk("tgt_answer", {acc, ret, la}, q.pop_front());
  end
  always @(posedge clk) rv_d <= rv;
  always @(negedge clk) if (rv_d === 1'b1) begin
    if (rq.size() == 0) chk("rd_extra", 34'h0, 34'h1);
    else begin
      chk("pp_rdata", {2'h0, ppr}, {2'h0, rq[0][63:32]});
      chk("pci_rdata", {2'h0, pcr}, {2'h0, rq[0][31:0]});
      void'(rq.pop_front());
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin n_mismatch++; results; end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    rall;
    wr(PLWM_SEL_SIZE0, 32'h1ff00000);
    wr(PLWM_SEL_SIZE1, 32'h0);
    wr(PLWM_SEL_BASE0, 32'h0);
    rnd = nx(rnd);
    wr(PLWM_SEL_BASE1, rnd);
    rall;
    tg(0, rnd);
    @(posedge clk) host <= 1;
    tg(1, ~rnd);
    @(posedge clk) begin host <= 0; setup <= 1; end
    for (int i = 0; i < 8; i++) begin
      rnd = nx(rnd);
      tg(rnd[0], rnd);
    end
    rnd = nx(rnd);
    wr(PLWM_SEL_SIZE0, 32'h01f00000);
    wr(PLWM_SEL_BASE0, rnd & 32'h1e000000);
    tg(0, 32'hffffffff);
    tg(0, rnd);
    wr(PLWM_SEL_SIZE0, 32'h0);
    wr(PLWM_SEL_BASE0, ~rnd);
    tg(0, rnd);
    @(posedge clk) srst <= 1;
    @(posedge clk) srst <= 0;
    m = '{default: 32'h0};
    rall;
    repeat (4) @(posedge clk);
    chk("pending", 34'(q.size() + rq.size()), 34'h0);
    results;
  end
endmodule // tb
